// >>> charger_timer_control_regs.sv
// Timer and charge control register bank with watchdog, safety timers and ship timing.
// Summary of operation
// - Top-off code: off, 15, 30, 45 minutes.
// - Trickle timer one hour when enabled.
// - Fast timer codes: 5, 8, 12 hours.
// - Half-rate counting during input/thermal regulation, outside top-off.
// - Separate pre-charge and fast timer enables.
// - Auto discharge during battery overvoltage fault.
// - Forced discharge regardless of overvoltage.
// - Charge enable bit gates charging.
// - Optimizer kick set-only, needs enable, self-clears.
// - High impedance bit cleared on adapter plug.
// - Overvoltage code: 26, 18, 12, 7 volts.
// - Watchdog kick restarts timer, self-clears.
// - Watchdog period code table, default 40 s.
// - Expiry restores watchdog fields; reset restores all.
// - Detection kick starts detection, clears when done.
// - Auto detection on input plug when enabled.
// - Handshake enable plus 9 V/12 V permits.
// - Ship switch code: idle, shutdown, ship, reset.
// - Ship action delayed ten seconds unless bypassed.
// - Gate-driver off forces both drivers off.
// - Reverse output bit, cleared by watchdog.
// - Wake hold one second or 15 ms.
module charger_timer_control_regs
  import charger_timer_pkg::*;
#(
  parameter int HALF_SEC_CYCLES   = HALF_SEC_CYCLES_DEF,
  parameter int WAKE_LONG_CYCLES  = WAKE_LONG_CYCLES_DEF,
  parameter int WAKE_SHORT_CYCLES = WAKE_SHORT_CYCLES_DEF
) (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_ce,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_ack,
  input  wire logic       i_reg_reset,
  input  wire logic       i_adapter_plugged,
  input  wire logic       i_optimizer_started,
  input  wire logic       i_detect_done,
  input  wire logic       i_batt_ovp,
  input  wire logic       i_in_regulation,
  input  wire phase_e     i_charge_phase,
  input  wire logic       i_precharge_short,
  input  wire logic       i_wake_pin_n,
  output ctrl_s           o_ctrl,
  output logic            o_watchdog_expired,
  output logic            o_safety_expired,
  output logic            o_detect_start,
  output logic            o_ship_fire,
  output logic            o_wake_exit
);

  state_s st_reg;
  state_s st_next;

  logic        half_tick;
  logic [3:0]  dec;
  logic [7:0]  wv;
  logic        wd_kick;
  logic [10:0] limit;
  logic        timer_on;
  logic [10:0] step;
  logic [10:0] sum;
  logic [26:0] hold;

  always_comb begin
    st_next = st_reg;
    st_next.ship_fire    = 1'b0;
    st_next.wake_exit    = 1'b0;
    st_next.detect_start = 1'b0;
    st_next.ack          = 1'b0;
    st_next.wd_expired   = 1'b0;
    dec     = addr_decode(i_reg_addr);
    wv      = i_reg_wdata & WR_MASK[dec[2:0]];
    wd_kick = 1'b0;
    limit   = 11'h000;
    timer_on = 1'b0;
    step    = 11'h002;
    sum     = 11'h000;
    hold    = 27'(WAKE_LONG_CYCLES);

    half_tick = (st_reg.half_pre == 26'(HALF_SEC_CYCLES - 1));
    st_next.half_pre = half_tick ? 26'h0 : st_reg.half_pre + 26'h1;

    if (i_adapter_plugged) begin
      st_next.regs[IDX_CTRL_A][BIT_HIZ] = 1'b0;
    end
    if (i_optimizer_started) begin
      st_next.regs[IDX_CTRL_A][BIT_OPT_KICK] = 1'b0;
    end
    if (i_detect_done) begin
      st_next.regs[IDX_CTRL_C][BIT_DET_KICK] = 1'b0;
    end
    st_next.regs[IDX_CTRL_B][BIT_WD_KICK] = 1'b0;

    if (i_adapter_plugged && st_reg.regs[IDX_CTRL_C][BIT_AUTO_DET]) begin
      st_next.detect_start = 1'b1;
    end

    // A write lands after the hardware clears so a coincident set is never lost.
    if (i_reg_wr && dec[3]) begin
      unique case (dec[2:0])
        IDX_CTRL_A: begin
          wv[BIT_OPT_KICK] = st_next.regs[IDX_CTRL_A][BIT_OPT_KICK] |
                             (wv[BIT_OPT_KICK] & wv[BIT_OPT_EN]);
        end
        IDX_CTRL_B: begin
          wd_kick = wv[BIT_WD_KICK];
        end
        IDX_CTRL_C: begin
          if (wv[BIT_DET_KICK] && !st_next.regs[IDX_CTRL_C][BIT_DET_KICK]) begin
            st_next.detect_start = 1'b1;
          end
          wv[BIT_DET_KICK] = wv[BIT_DET_KICK] | st_next.regs[IDX_CTRL_C][BIT_DET_KICK];
          st_next.ship_wait = 1'b0;
          st_next.ship_cnt  = 5'h00;
          if (wv[BIT_SHIP_LSB +: 2] != 2'b00) begin
            if (wv[BIT_SHIP_NODLY]) begin
              st_next.ship_fire = 1'b1;
            end else begin
              st_next.ship_wait = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
      st_next.regs[dec[2:0]] = wv;
    end

    if (st_reg.ship_wait && half_tick) begin
      if (st_reg.ship_cnt == SHIP_DELAY_HALF_SEC - 5'h01) begin
        st_next.ship_fire = 1'b1;
        st_next.ship_wait = 1'b0;
      end else begin
        st_next.ship_cnt = st_reg.ship_cnt + 5'h01;
      end
    end

    if (st_reg.regs[IDX_CTRL_B][2:0] == 3'h0 || wd_kick || i_reg_reset) begin
      st_next.wd_cnt = 9'h000;
    end else if (half_tick) begin
      if (st_reg.wd_cnt + 9'h001 >= wd_period(st_reg.regs[IDX_CTRL_B][2:0])) begin
        st_next.wd_cnt     = 9'h000;
        st_next.wd_expired = 1'b1;
      end else begin
        st_next.wd_cnt = st_reg.wd_cnt + 9'h001;
      end
    end

    for (int i = 0; i < 5; i++) begin
      if (i_reg_reset) begin
        st_next.regs[i] = (st_next.regs[i] & ~REG_MASK[i]) | (RST_VALS[i] & REG_MASK[i]);
      end else if (st_next.wd_expired) begin
        st_next.regs[i] = (st_next.regs[i] & ~WD_MASK[i]) | (RST_VALS[i] & WD_MASK[i]);
      end
    end
    if (i_reg_reset) begin
      st_next.ship_wait = 1'b0;
    end

    st_next.discharge_on = st_reg.regs[IDX_CTRL_A][BIT_FORCE_DIS] |
                           (st_reg.regs[IDX_CTRL_A][BIT_AUTO_DIS] & i_batt_ovp);

    // Safety timer limit per phase, in minutes.
    unique case (i_charge_phase)
      PH_TRICKLE: begin
        limit    = TRICKLE_MIN;
        timer_on = st_reg.regs[IDX_TIMER][BIT_TRICKLE_EN];
      end
      PH_PRE: begin
        limit    = i_precharge_short ? PRE_SHORT_MIN : PRE_LONG_MIN;
        timer_on = st_reg.regs[IDX_TIMER][BIT_PRECHG_EN];
      end
      PH_FAST: begin
        unique case (st_reg.regs[IDX_TIMER][BIT_FAST_LSB +: 2])
          2'h0:    limit = FAST5_MIN;
          2'h1:    limit = FAST8_MIN;
          default: limit = FAST12_MIN;
        endcase
        timer_on = st_reg.regs[IDX_TIMER][BIT_FASTCHG_EN];
      end
      PH_TOPOFF: begin
        limit = 11'(TOPOFF_STEP_MIN * st_reg.regs[IDX_TIMER][BIT_TOPOFF_LSB +: 2]);
        timer_on = (limit != 11'h000);
      end
      default: begin
        limit    = 11'h000;
        timer_on = 1'b0;
      end
    endcase

    if (st_reg.regs[IDX_TIMER][BIT_HALF_RATE] && i_in_regulation && i_charge_phase != PH_TOPOFF) begin
      step = 11'h001;
    end
    sum = st_reg.safe_cnt + step;
    st_next.phase_prev = i_charge_phase;
    if (!timer_on || !st_reg.regs[IDX_CTRL_A][BIT_CHG_EN] ||
        i_charge_phase != st_reg.phase_prev) begin
      st_next.safe_cnt     = 11'h000;
      st_next.min_pre      = 7'h00;
      st_next.safe_expired = 1'b0;
    end else if (half_tick && !st_reg.safe_expired) begin
      if (st_reg.min_pre == HALF_SEC_PER_MIN - 7'h01) begin
        st_next.min_pre = 7'h00;
        // Counts in half-minute steps so a slowed timer advances by one.
        if (sum >= {limit[9:0], 1'b0}) begin
          st_next.safe_expired = 1'b1;
        end
        st_next.safe_cnt = sum;
      end else begin
        st_next.min_pre = st_reg.min_pre + 7'h01;
      end
    end

    // wake hold filtered from the pin
    st_next.wake_sync = {st_reg.wake_sync[1:0], i_wake_pin_n};
    if (st_reg.wake_sync[1] == st_reg.wake_sync[2]) begin
      st_next.wake_low = ~st_reg.wake_sync[2];
    end
    if (st_reg.regs[IDX_CTRL_D][BIT_WAKE_SEL]) begin
      hold = 27'(WAKE_SHORT_CYCLES);
    end
    if (!st_reg.wake_low) begin
      st_next.wake_cnt = 27'h0;
    end else if (st_reg.wake_cnt != hold) begin
      st_next.wake_cnt = st_reg.wake_cnt + 27'h1;
      if (st_reg.wake_cnt + 27'h1 == hold) begin
        st_next.wake_exit = 1'b1;
      end
    end

    // Register reads answer one cycle later; unmapped offsets read zero.
    if (i_reg_rd || i_reg_wr) begin
      st_next.ack   = 1'b1;
      st_next.rdata = dec[3] ? st_reg.regs[dec[2:0]] : 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg           <= '0;
      st_reg.regs      <= RST_VALS;
      // The pin idles high, so the filter starts there to avoid a false hold after reset.
      st_reg.wake_sync <= 3'h7;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_reg_rdata        = st_reg.rdata;
  assign o_reg_ack          = st_reg.ack;
  assign o_watchdog_expired = st_reg.wd_expired;
  assign o_safety_expired   = st_reg.safe_expired;
  assign o_detect_start     = st_reg.detect_start;
  assign o_ship_fire        = st_reg.ship_fire;
  assign o_wake_exit        = st_reg.wake_exit;

  always_comb begin
    o_ctrl.topoff_time_sel        = st_reg.regs[IDX_TIMER][BIT_TOPOFF_LSB +: 2];
    o_ctrl.trickle_timer_en       = st_reg.regs[IDX_TIMER][BIT_TRICKLE_EN];
    o_ctrl.precharge_timer_en     = st_reg.regs[IDX_TIMER][BIT_PRECHG_EN];
    o_ctrl.fastcharge_timer_en    = st_reg.regs[IDX_TIMER][BIT_FASTCHG_EN];
    o_ctrl.fastcharge_time_sel    = st_reg.regs[IDX_TIMER][BIT_FAST_LSB +: 2];
    o_ctrl.half_rate_timer_en     = st_reg.regs[IDX_TIMER][BIT_HALF_RATE];
    o_ctrl.discharge_on           = st_reg.discharge_on;
    o_ctrl.charging_en            = st_reg.regs[IDX_CTRL_A][BIT_CHG_EN];
    o_ctrl.optimizer_en           = st_reg.regs[IDX_CTRL_A][BIT_OPT_EN];
    o_ctrl.optimizer_kick         = st_reg.regs[IDX_CTRL_A][BIT_OPT_KICK];
    o_ctrl.high_impedance_en      = st_reg.regs[IDX_CTRL_A][BIT_HIZ];
    o_ctrl.termination_en         = st_reg.regs[IDX_CTRL_A][BIT_TERM_EN];
    o_ctrl.input_overvolt_sel     = st_reg.regs[IDX_CTRL_B][BIT_OVP_LSB +: 2];
    o_ctrl.auto_adapter_detect_en = st_reg.regs[IDX_CTRL_C][BIT_AUTO_DET];
    o_ctrl.hv_port_handshake_en   = st_reg.regs[IDX_CTRL_C][BIT_HVDCP];
    o_ctrl.nine_volt_permit       = st_reg.regs[IDX_CTRL_C][BIT_9V] &
                                    st_reg.regs[IDX_CTRL_C][BIT_HVDCP];
    o_ctrl.twelve_volt_permit     = st_reg.regs[IDX_CTRL_C][BIT_12V] &
                                    st_reg.regs[IDX_CTRL_C][BIT_HVDCP];
    o_ctrl.ship_switch_action     = st_reg.regs[IDX_CTRL_C][BIT_SHIP_LSB +: 2];
    o_ctrl.gate_drivers_off       = st_reg.regs[IDX_CTRL_D][BIT_GATES_OFF];
    o_ctrl.reverse_output_en      = st_reg.regs[IDX_CTRL_D][BIT_OTG_EN];
    o_ctrl.pfm_otg_off            = st_reg.regs[IDX_CTRL_D][BIT_PFM_OTG_OFF];
    o_ctrl.pfm_fwd_off            = st_reg.regs[IDX_CTRL_D][BIT_PFM_FWD_OFF];
    o_ctrl.ldo_off                = st_reg.regs[IDX_CTRL_D][BIT_LDO_OFF];
    o_ctrl.otg_ooa_off            = st_reg.regs[IDX_CTRL_D][BIT_OTG_OOA_OFF];
    o_ctrl.fwd_ooa_off            = st_reg.regs[IDX_CTRL_D][BIT_FWD_OOA_OFF];
  end

endmodule

// >>> charger_timer_control_regs_tb.sv
// Self-checking bench for the timer and charge control register bank.
module charger_timer_control_regs_tb
  import charger_timer_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MIN_CYC = 120 * 8;
  typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_s;
  logic       i_clk, i_arst_n, i_ce, i_reg_wr, i_reg_rd, i_reg_reset, i_adapter_plugged;
  logic       i_optimizer_started, i_detect_done, i_batt_ovp, i_in_regulation;
  logic       i_precharge_short, i_wake_pin_n, o_reg_ack, o_watchdog_expired;
  logic       o_safety_expired, o_detect_start, o_ship_fire, o_wake_exit;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  phase_e     i_charge_phase;
  ctrl_s      o_ctrl;
  int         fail_count, n_checks;
  logic [7:0] rst_exp [5] = '{8'h3D, 8'hA2, 8'h85, 8'h40, 8'h00};
  row_s       rows [15] = '{
    '{8'h0E, 8'h40, 8'h40}, '{8'h0E, 8'h80, 8'h80}, '{8'h0E, 8'hC2, 8'hC2},
    '{8'h0F, 8'h45, 8'h44}, '{8'h0F, 8'h08, 8'h00}, '{8'h0F, 8'h18, 8'h18},
    '{8'h0F, 8'h00, 8'h08}, '{8'h10, 8'hF0, 8'h30}, '{8'h10, 8'h10, 8'h10},
    '{8'h10, 8'h20, 8'h20}, '{8'h11, 8'h38, 8'h38}, '{8'h11, 8'h30, 8'h30},
    '{8'h12, 8'hFF, 8'hFF}, '{8'h12, 8'h00, 8'h00}, '{8'h20, 8'h55, 8'h00}};

  charger_timer_control_regs #(.HALF_SEC_CYCLES(8), .WAKE_LONG_CYCLES(20),
    .WAKE_SHORT_CYCLES(5)) dut_u (.i_clk, .i_arst_n, .i_ce, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_ack, .i_reg_reset, .i_adapter_plugged,
    .i_optimizer_started, .i_detect_done, .i_batt_ovp, .i_in_regulation, .i_charge_phase,
    .i_precharge_short, .i_wake_pin_n, .o_ctrl, .o_watchdog_expired, .o_safety_expired,
    .o_detect_start, .o_ship_fire, .o_wake_exit);
  reg_port_host host_u (.i_clk(i_clk), .i_reg_ack(o_reg_ack), .i_reg_rdata(o_reg_rdata),
    .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr),
    .o_reg_wdata(i_reg_wdata));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic miss(input string msg);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) miss($sformatf("got %h expected %h", got, exp));
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    logic ok;
    host_u.access(w, a, d, r, ok);
    if (ok !== 1'b1) begin
      miss("register port gave no answer");
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    acc(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    acc(1'b0, a, 8'h00, r);
    chk8(r, exp);
  endtask
  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic pulse(input int sel);
    @(posedge i_clk);
    #1;
    case (sel)
      0: i_optimizer_started = 1'b1;
      1: i_detect_done = 1'b1;
      2: i_adapter_plugged = 1'b1;
      default: i_reg_reset = 1'b1;
    endcase
    @(posedge i_clk);
    #1;
    {i_optimizer_started, i_detect_done, i_adapter_plugged, i_reg_reset} = 4'h0;
  endtask
  function automatic logic ev(input int sel);
    case (sel)
      0: return o_watchdog_expired;
      1: return o_ship_fire;
      2: return o_wake_exit;
      3: return o_safety_expired;
      default: return o_detect_start;
    endcase
  endfunction
  // Counts cycles until the selected event, which must land within lo..hi+1.
  task automatic meas(input int sel, input int lo, input int hi);
    int n;
    n = 0;
    while (ev(sel) !== 1'b1 && n <= hi) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    n_checks++;
    if (ev(sel) !== 1'b1 || n < lo) miss($sformatf("event %0d after %0d cycles", sel, n));
  endtask

  initial begin
    {i_arst_n, i_reg_reset, i_adapter_plugged, i_optimizer_started, i_detect_done} = 5'h0;
    {i_batt_ovp, i_in_regulation, i_precharge_short} = 3'h0;
    i_ce = 1'b1;
    i_wake_pin_n = 1'b1;
    i_charge_phase = PH_IDLE;
    repeat (20) @(posedge i_clk);
    #1;
    i_arst_n = 1'b1;
    for (int i = 0; i < 5; i++) rd_chk(8'h0E + 8'(i), rst_exp[i]);
    wr(8'h10, 8'h00);
    for (int i = 0; i < 15; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    pulse(0);
    rd_chk(8'h0F, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h10, 8'(k << 4));
      chk8(8'(o_ctrl.input_overvolt_sel), 8'(k));
    end
    $display("done: table and codes");
    i_batt_ovp = 1'b1;
    wr(8'h0F, 8'h80);
    settle();
    chk8({o_ctrl.discharge_on, o_ctrl.charging_en}, 8'h2);
    wr(8'h0F, 8'h00);
    settle();
    chk8(8'(o_ctrl.discharge_on), 8'h0);
    i_batt_ovp = 1'b0;
    wr(8'h0F, 8'h40);
    settle();
    chk8({o_ctrl.discharge_on, o_ctrl.charging_en}, 8'h2);
    $display("done: discharge");
    wr(8'h11, 8'hC0);
    meas(4, 0, 3);
    rd_chk(8'h11, 8'hC0);
    pulse(1);
    rd_chk(8'h11, 8'h40);
    wr(8'h0F, 8'h04);
    pulse(2);
    rd_chk(8'h0F, 8'h00);
    wr(8'h10, 8'h08);
    rd_chk(8'h10, 8'h00);
    $display("done: events");
    wr(8'h10, 8'h09);
    meas(0, 0, 9);
    rd_chk(8'h0F, 8'h22);
    wr(8'h10, 8'h0A);
    meas(0, 7, 17);
    wr(8'h10, 8'h00);
    $display("done: watchdog");
    for (int k = 1; k < 4; k++) begin
      wr(8'h11, 8'((k << 1) | 1));
      meas(1, 0, 3);
      chk8(8'(o_ctrl.ship_switch_action), 8'(k));
    end
    wr(8'h11, 8'h04);
    meas(1, 150, 172);
    wr(8'h11, 8'h00);
    $display("done: ship");
    i_wake_pin_n = 1'b0;
    meas(2, 20, 28);
    i_wake_pin_n = 1'b1;
    wr(8'h12, 8'h08);
    settle();
    i_wake_pin_n = 1'b0;
    meas(2, 5, 12);
    i_wake_pin_n = 1'b1;
    $display("done: wake");
    wr(8'h0E, 8'h40);
    i_charge_phase = PH_TOPOFF;
    meas(3, 15 * MIN_CYC - MIN_CYC, 15 * MIN_CYC + MIN_CYC);
    i_charge_phase = PH_IDLE;
    settle();
    chk8(8'(o_safety_expired), 8'h0);
    wr(8'h0E, 8'h11);
    {i_in_regulation, i_precharge_short} = 2'h3;
    i_charge_phase = PH_PRE;
    meas(3, 60 * MIN_CYC - 2 * MIN_CYC, 60 * MIN_CYC + 2 * MIN_CYC);
    i_charge_phase = PH_IDLE;
    $display("done: safety");
    wr(8'h12, 8'h40);
    pulse(3);
    for (int i = 0; i < 5; i++) rd_chk(8'h0E + 8'(i), rst_exp[i]);
    $display("done: register reset");
    test_done();
  end
endmodule

// >>> charger_timer_pkg.sv
// Constants, types and decode helpers shared by the charger timer/control register bank.
package charger_timer_pkg;

  // Register offsets on the register port.
  localparam logic [7:0] ADDR_TIMER_SETUP = 8'h0E;
  localparam logic [7:0] ADDR_CTRL_A      = 8'h0F;
  localparam logic [7:0] ADDR_CTRL_B      = 8'h10;
  localparam logic [7:0] ADDR_CTRL_C      = 8'h11;
  localparam logic [7:0] ADDR_CTRL_D      = 8'h12;

  // Indices into the register array.
  localparam logic [2:0] IDX_TIMER  = 3'h0;
  localparam logic [2:0] IDX_CTRL_A = 3'h1;
  localparam logic [2:0] IDX_CTRL_B = 3'h2;
  localparam logic [2:0] IDX_CTRL_C = 3'h3;
  localparam logic [2:0] IDX_CTRL_D = 3'h4;

  // Reset values, index 0 at the low end.
  localparam logic [4:0][7:0] RST_VALS = {8'h00, 8'h40, 8'h85, 8'hA2, 8'h3D};
  // Bits restored on watchdog expiry.
  localparam logic [4:0][7:0] WD_MASK  = {8'h66, 8'hC0, 8'h08, 8'h2A, 8'hFF};
  // Bits restored on register reset.
  localparam logic [4:0][7:0] REG_MASK = {8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'hFF};
  // Writable bits; a write zeroes reserved bits, though control b bit 7 resets to one.
  localparam logic [4:0][7:0] WR_MASK  = {8'hFF, 8'hFF, 8'h3F, 8'hFE, 8'hFF};

  // Field positions, safety timer setup.
  localparam int BIT_TOPOFF_LSB  = 6;
  localparam int BIT_TRICKLE_EN  = 5;
  localparam int BIT_PRECHG_EN   = 4;
  localparam int BIT_FASTCHG_EN  = 3;
  localparam int BIT_FAST_LSB    = 1;
  localparam int BIT_HALF_RATE   = 0;
  // Charge control a.
  localparam int BIT_AUTO_DIS    = 7;
  localparam int BIT_FORCE_DIS   = 6;
  localparam int BIT_CHG_EN      = 5;
  localparam int BIT_OPT_EN      = 4;
  localparam int BIT_OPT_KICK    = 3;
  localparam int BIT_HIZ         = 2;
  localparam int BIT_TERM_EN     = 1;
  // Charge control b.
  localparam int BIT_OVP_LSB     = 4;
  localparam int BIT_WD_KICK     = 3;
  localparam int BIT_WD_LSB      = 0;
  // Charge control c.
  localparam int BIT_DET_KICK    = 7;
  localparam int BIT_AUTO_DET    = 6;
  localparam int BIT_12V         = 5;
  localparam int BIT_9V          = 4;
  localparam int BIT_HVDCP       = 3;
  localparam int BIT_SHIP_LSB    = 1;
  localparam int BIT_SHIP_NODLY  = 0;
  // Charge control d.
  localparam int BIT_GATES_OFF   = 7;
  localparam int BIT_OTG_EN      = 6;
  localparam int BIT_PFM_OTG_OFF = 5;
  localparam int BIT_PFM_FWD_OFF = 4;
  localparam int BIT_WAKE_SEL    = 3;
  localparam int BIT_LDO_OFF     = 2;
  localparam int BIT_OTG_OOA_OFF = 1;
  localparam int BIT_FWD_OOA_OFF = 0;

  // Timing, each time in its own unit.
  localparam int CLK_PERIOD_NS   = 10;
  localparam int HALF_SEC_MS     = 500;
  localparam int WAKE_LONG_MS    = 1000;
  localparam int WAKE_SHORT_MS   = 15;
  localparam int SHIP_DELAY_S    = 10;
  localparam int HALF_SEC_CYCLES_DEF = HALF_SEC_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WAKE_LONG_CYCLES_DEF  = WAKE_LONG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WAKE_SHORT_CYCLES_DEF = WAKE_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [4:0] SHIP_DELAY_HALF_SEC = 5'(SHIP_DELAY_S * 1000 / HALF_SEC_MS);
  localparam logic [6:0] HALF_SEC_PER_MIN    = 7'h78;

  // Safety-timer limits in minutes.
  localparam logic [10:0] TRICKLE_MIN  = 11'h03C;
  localparam logic [10:0] PRE_LONG_MIN = 11'h078;
  localparam logic [10:0] PRE_SHORT_MIN = 11'h01E;
  localparam logic [10:0] FAST5_MIN    = 11'h12C;
  localparam logic [10:0] FAST8_MIN    = 11'h1E0;
  localparam logic [10:0] FAST12_MIN   = 11'h2D0;
  localparam logic [10:0] TOPOFF_STEP_MIN = 11'h00F;

  typedef enum logic [2:0] {PH_IDLE, PH_TRICKLE, PH_PRE, PH_FAST, PH_TOPOFF} phase_e;

  typedef struct packed {
    logic [1:0] topoff_time_sel;
    logic       trickle_timer_en;
    logic       precharge_timer_en;
    logic       fastcharge_timer_en;
    logic [1:0] fastcharge_time_sel;
    logic       half_rate_timer_en;
    logic       discharge_on;
    logic       charging_en;
    logic       optimizer_en;
    logic       optimizer_kick;
    logic       high_impedance_en;
    logic       termination_en;
    logic [1:0] input_overvolt_sel;
    logic       auto_adapter_detect_en;
    logic       hv_port_handshake_en;
    logic       nine_volt_permit;
    logic       twelve_volt_permit;
    logic [1:0] ship_switch_action;
    logic       gate_drivers_off;
    logic       reverse_output_en;
    logic       pfm_otg_off;
    logic       pfm_fwd_off;
    logic       ldo_off;
    logic       otg_ooa_off;
    logic       fwd_ooa_off;
  } ctrl_s;

  typedef struct packed {
    logic [4:0][7:0] regs;
    logic [25:0]     half_pre;
    logic [8:0]      wd_cnt;
    logic            wd_expired;
    logic [6:0]      min_pre;
    logic [10:0]     safe_cnt;
    logic            safe_expired;
    phase_e          phase_prev;
    logic            discharge_on;
    logic            ship_wait;
    logic [4:0]      ship_cnt;
    logic            ship_fire;
    logic [2:0]      wake_sync;
    logic            wake_low;
    logic [26:0]     wake_cnt;
    logic            wake_exit;
    logic            detect_start;
    logic [7:0]      rdata;
    logic            ack;
  } state_s;

  // Maps a port address to a register index.
  function automatic logic [3:0] addr_decode(input logic [7:0] addr);
    logic [3:0] r;
    r = 4'h0;
    if (addr >= ADDR_TIMER_SETUP && addr <= ADDR_CTRL_D) begin
      r = {1'b1, 3'(addr - ADDR_TIMER_SETUP)};
    end
    return r;
  endfunction

  // Watchdog period in half-second units, zero when disabled.
  function automatic logic [8:0] wd_period(input logic [2:0] sel);
    logic [8:0] r;
    r = 9'h000;
    unique case (sel)
      3'h0: r = 9'h000;
      3'h1: r = 9'h001;
      3'h2: r = 9'h002;
      3'h3: r = 9'h004;
      3'h4: r = 9'h028;
      3'h5: r = 9'h050;
      3'h6: r = 9'h0A0;
      3'h7: r = 9'h140;
    endcase
    return r;
  endfunction

endpackage

// >>> charger_timer_sva.sv
// Port-level assertions for the timer and charge control bank.
module charger_timer_sva
  import charger_timer_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic       i_ce,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_reg_ack,
  input wire logic       i_reg_reset,
  input wire logic       i_adapter_plugged,
  input wire ctrl_s      o_ctrl,
  input wire logic       o_watchdog_expired,
  input wire logic       o_detect_start,
  input wire logic       o_ship_fire
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  logic acc;
  assign acc = i_ce && (i_reg_wr || i_reg_rd);

  sequence ship_wr_s;
    i_ce && i_reg_wr && !i_reg_reset && i_reg_addr == ADDR_CTRL_C && i_reg_wdata[2:1] != 2'h0;
  endsequence

  a_ack_after_access : assert property (acc |=> o_reg_ack)
    else $error("no acknowledge after an access");
  a_no_idle_ack : assert property (i_ce && !acc |=> !o_reg_ack)
    else $error("acknowledge without an access");
  a_unmapped_reads_zero : assert property (acc && i_reg_rd &&
    (i_reg_addr < ADDR_TIMER_SETUP || i_reg_addr > ADDR_CTRL_D) |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_permit_gated : assert property (!o_ctrl.hv_port_handshake_en |->
    !o_ctrl.nine_volt_permit && !o_ctrl.twelve_volt_permit) else $error("permit without handshake");
  a_hiz_plug_clear : assert property (i_ce && i_adapter_plugged &&
    !(i_reg_wr && i_reg_addr == ADDR_CTRL_A) |=> !o_ctrl.high_impedance_en)
    else $error("high impedance kept after plug");
  a_detect_on_plug : assert property (i_ce && i_adapter_plugged &&
    o_ctrl.auto_adapter_detect_en |-> ##[1:2] o_detect_start) else $error("no detection on plug");
  a_wd_restore : assert property (o_watchdog_expired |-> o_ctrl.charging_en &&
    !o_ctrl.reverse_output_en && o_ctrl.fastcharge_time_sel == 2'h2) else $error("fields not restored");
  a_wd_single_pulse : assert property (o_watchdog_expired |=> !o_watchdog_expired)
    else $error("expiry pulse too long");
  a_reg_reset_defaults : assert property (i_ce && i_reg_reset |=> o_ctrl.charging_en &&
    o_ctrl.input_overvolt_sel == 2'h0 && o_ctrl.ship_switch_action == 2'h0 &&
    o_ctrl.auto_adapter_detect_en && o_ctrl.topoff_time_sel == 2'h0) else $error("reset lost");
  a_ship_nodelay : assert property (ship_wr_s ##0 i_reg_wdata[0] |-> ##[1:3] o_ship_fire)
    else $error("undelayed ship action late");
  a_ship_delayed : assert property (ship_wr_s ##0 !i_reg_wdata[0] |=> !o_ship_fire [*8])
    else $error("delayed ship action early");
endmodule

bind charger_timer_control_regs charger_timer_sva sva_u (.i_clk, .i_arst_n, .i_ce, .i_reg_wr,
  .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_ack, .i_reg_reset,
  .i_adapter_plugged, .o_ctrl, .o_watchdog_expired, .o_detect_start, .o_ship_fire);

// >>> reg_port_host.sv
// Host model that issues single-byte accesses on the bank's register port.
module reg_port_host (
  input  wire logic       i_clk,
  input  wire logic       i_reg_ack,
  input  wire logic [7:0] i_reg_rdata,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [7:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_addr  = 8'hFF;
    o_reg_wdata = 8'h00;
  end

  // The strobe is a one-cycle pulse; the answer is awaited for a bounded time.
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] r, output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    r  = 8'h00;
    @(posedge i_clk);
    #1;
    o_reg_wr    = w;
    o_reg_rd    = ~w;
    o_reg_addr  = a;
    o_reg_wdata = d;
    @(posedge i_clk);
    #1;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    // Released lines show the inverse so a stale value never passes for a live one.
    o_reg_addr  = ~a;
    o_reg_wdata = ~d;
    while (ok !== 1'b1 && n < 4) begin
      if (i_reg_ack === 1'b1) begin
        ok = 1'b1;
        r  = i_reg_rdata;
      end else begin
        @(posedge i_clk);
        #1;
        n++;
      end
    end
  endtask
endmodule
